// file: common/prom_tap_pkg.sv
package prom_tap_pkg;

    // Instruction register geometry and opcodes
    localparam int         IR_W        = 8;
    localparam logic [7:0] OP_BYPASS   = 8'hff;
    localparam logic [7:0] OP_SAMPLE   = 8'h01;
    localparam logic [7:0] OP_EXTEST   = 8'h00;
    localparam logic [7:0] OP_CLAMP    = 8'hfa;
    localparam logic [7:0] OP_HIGHZ    = 8'hfc;
    localparam logic [7:0] OP_DEVICE_IDENTITY_REG   = 8'hfe;
    localparam logic [7:0] OP_USER_SCRATCH_CODE = 8'hfd;
    localparam logic [7:0] OP_CONFIG   = 8'hee;
    localparam logic [7:0] IR_RST      = OP_DEVICE_IDENTITY_REG;

    // Capture pattern: fixed bits plus two status positions
    localparam logic [7:0] CAP_FIXED   = 8'h01;
    localparam int         CAP_ISP_BIT = 4;
    localparam int         CAP_SEC_BIT = 3;

    // Identification word layout
    localparam int          ID_W        = 32;
    localparam int          ID_VER_LSB  = 28;
    localparam int          ID_FAM_LSB  = 20;
    localparam int          ID_PROD_LSB = 12;
    localparam int          ID_COMP_LSB = 1;
    localparam logic [3:0]  ID_VER_DEF  = 4'h1;    // Arbitrary value
    localparam logic [7:0]  ID_FAM_DEF  = 8'h5a;   // Arbitrary value
    localparam logic [7:0]  ID_PROD_DEF = 8'h3c;   // Arbitrary value
    localparam logic [10:0] ID_COMP_DEF = 11'h0a5; // Arbitrary value
    localparam logic [31:0] USER_SCRATCH_CODE_BLANK = 32'hffffffff;
    localparam logic        SECURE_RST  = 1'b0;

    // Reload pulse timing on the 200 MHz reference clock
    localparam int REF_CLK_MHZ      = 200;
    localparam int CFG_PULSE_MIN_NS = 300;
    localparam int CFG_PULSE_MAX_NS = 500;
    localparam int CFG_PULSE_CYCLES = (CFG_PULSE_MIN_NS * REF_CLK_MHZ + 999) / 1000;
    localparam int CFG_PULSE_MAX_CYCLES = (CFG_PULSE_MAX_NS * REF_CLK_MHZ) / 1000;

    typedef enum logic [3:0] {
        TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
        SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
    } tap_state_t;

    typedef enum logic [1:0] {DR_BYPASS, DR_ID, DR_USER, DR_BSR} dr_sel_t;

endpackage

// file: rtl/cfg_pulse_gen.sv
`timescale 1ns/1ps
`default_nettype none
module cfg_pulse_gen (
    input  wire logic ref_clk,
    input  wire logic rst,
    input  wire logic reqToggle,
    output logic      pulseActive
);
    import prom_tap_pkg::*;

    localparam int CW = $clog2(CFG_PULSE_CYCLES + 1);

    logic          syncA_q, syncB_q, syncC_q;
    logic [CW-1:0] count_q;
    logic [CW-1:0] widthCnt_q;

    // Toggle crossing from the test clock; syncA feeds syncB, and syncB and syncC feed the edge detect
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            syncA_q <= 1'b0;
            syncB_q <= 1'b0;
            syncC_q <= 1'b0;
        end else begin
            syncA_q <= reqToggle;
            syncB_q <= syncA_q;
            syncC_q <= syncB_q;
        end
    end

    // Low pulse held for the minimum width, well under the maximum
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            count_q     <= '0;
            pulseActive <= 1'b0;
        end else if (syncB_q ^ syncC_q) begin
            count_q     <= CW'(CFG_PULSE_CYCLES - 1);
            pulseActive <= 1'b1;
        end else if (count_q != '0) begin
            count_q <= count_q - 1'b1;
        end else begin
            pulseActive <= 1'b0;
        end
    end

    // Pulse length meter for checking
    always_ff @(posedge ref_clk) begin
        if (rst || !pulseActive) begin
            widthCnt_q <= '0;
        end else begin
            widthCnt_q <= widthCnt_q + 1'b1;
        end
    end

    a_pulse_width: assert property (@(posedge ref_clk) disable iff (rst)
        $fell(pulseActive) |-> ($past(widthCnt_q) + 1 >= CFG_PULSE_CYCLES
                                && $past(widthCnt_q) + 1 <= CFG_PULSE_MAX_CYCLES))
        else $error("reload pulse width out of range");

endmodule // cfg_pulse_gen
`default_nettype wire

// file: rtl/prom_tap_top.sv
// Functional notes
// - Security set blocks every array readout through the test port.
// - Only a full erase clears the security bit; here reset also clears it, loading SECURE_RST (0).
// - Unsecured allows read, program, erase; secured still allows erase.
// - Eight-bit instruction register sits between tdi and tdo in instruction scans.
// - Ones is bypass, 00000001 sample/preload, zeros external test.
// - Decode clamp, high impedance for all outputs, and reload command.
// - Identity and user code instructions select their 32-bit registers.
// - Instruction capture loads a fixed pattern, shifted out low bit first.
// - Capture bit 4 shows programming mode, bit 3 shows security.
// - Other capture bits are 000, 0 and 01.
// - Boundary register: two cells per output pin, one per input pin.
// - Output value cell nearer tdi, high-impedance cell nearer tdo.
// - Identity word: version, family, product, company, low bit one.
// - User code holds programmed value, all ones when blank.
// - One four-wire port serves test and programming.
// - Reload drives the trigger low for 300 to 500 ns.
// - During programming every output floats or holds clamp value; here extest also drives them from the update latches.
// - Mode select sampled each rising test clock drives the controller.
`timescale 1ns/1ps
`default_nettype none
module prom_tap_top #(
    parameter int          NOUT    = 8,
    parameter int          NIN     = 4,
    parameter logic [3:0]  ID_VER  = prom_tap_pkg::ID_VER_DEF,  // Arbitrary value
    parameter logic [7:0]  ID_FAM  = prom_tap_pkg::ID_FAM_DEF,  // Arbitrary value
    parameter logic [7:0]  ID_PROD = prom_tap_pkg::ID_PROD_DEF, // Arbitrary value
    parameter logic [10:0] ID_COMP = prom_tap_pkg::ID_COMP_DEF  // Arbitrary value
) (
    input  wire logic            ref_clk,
    input  wire logic            rst,
    input  wire logic            tck,
    input  wire logic            tms,
    input  wire logic            tdi,
    output logic                 tdoOut,
    output logic                 tdoOe,
    input  wire logic            configTriggerNIn,
    output logic                 configTriggerNOut,
    output logic                 configTriggerNOe,
    output logic                 configTriggerSeen,
    input  wire logic            insystemProgActive,
    input  wire logic            secureSet,
    input  wire logic            eraseAllDone,
    input  wire logic            userCodeLoad,
    input  wire logic [31:0]     userCodeIn,
    input  wire logic            arrayReadReq,
    input  wire logic            progReq,
    input  wire logic            eraseReq,
    output logic                 arrayReadGrant,
    output logic                 progGrant,
    output logic                 eraseGrant,
    output logic                 securityActive,
    output logic [7:0]           activeInstr,
    input  wire logic [NOUT-1:0] coreOut,
    input  wire logic [NOUT-1:0] coreOe,
    input  wire logic [NIN-1:0]  pinIn,
    output logic [NOUT-1:0]      pinOut,
    output logic [NOUT-1:0]      pinOe
);
    import prom_tap_pkg::*;

    localparam int BSR_LEN = NIN + 2 * NOUT;
    localparam logic [31:0] ID_WORD = {ID_VER, ID_FAM, ID_PROD, ID_COMP, 1'b1};

    // Data register chosen by an opcode; unknown codes fall to bypass
    function automatic dr_sel_t drSelect(input logic [7:0] op);
        case (op)
            OP_DEVICE_IDENTITY_REG:            drSelect = DR_ID;
            OP_USER_SCRATCH_CODE:          drSelect = DR_USER;
            OP_SAMPLE, OP_EXTEST: drSelect = DR_BSR;
            default:              drSelect = DR_BYPASS;
        endcase
    endfunction

    // Opcodes whose pins come from the boundary update latches
    function automatic logic drivesPins(input logic [7:0] op);
        drivesPins = (op == OP_EXTEST) || (op == OP_CLAMP);
    endfunction

    tap_state_t           state;
    dr_sel_t              drSel;
    logic                 rstSyncA_q, rstTck;
    logic [7:0]           irShift_q, instr_q, capPattern;
    logic                 bypass_q;
    logic [ID_W-1:0]      idShift_q, user_scratch_code_q;
    logic [BSR_LEN-1:0]   bsrCap, bsrShift_q, bsrUpd_q;
    logic [NIN-1:0]       pinSyncA_q, pinSyncB_q;
    logic                 secure_q, cfgToggle_q, tdoBit;
    logic                 trigSyncA_q, trigSyncB_q;

    // Controller on the link clock; no other port exists for programming
    tap_state_fsm u_fsm (
        .tck    (tck),
        .rstTck (rstTck),
        .tms    (tms),
        .state  (state)
    );

    // Reset carried into the test clock domain
    always_ff @(posedge tck) begin
        rstSyncA_q <= rst;
        rstTck     <= rstSyncA_q;
    end

    // Input pins are asynchronous to the test clock
    always_ff @(posedge tck) begin
        pinSyncA_q <= pinIn;
        pinSyncB_q <= pinSyncA_q;
    end

    assign drSel = drSelect(instr_q);

    // Capture pattern with programming and security status
    always_comb begin
        capPattern              = CAP_FIXED;
        capPattern[CAP_ISP_BIT] = insystemProgActive;
        capPattern[CAP_SEC_BIT] = secure_q;
    end

    // Instruction shift path, loaded at capture, shifted low bit first
    always_ff @(posedge tck) begin
        if (rstTck) begin
            irShift_q <= CAP_FIXED;
        end else if (state == CAP_IR) begin
            irShift_q <= capPattern;
        end else if (state == SH_IR) begin
            irShift_q <= {tdi, irShift_q[IR_W-1:1]};
        end
    end

    // Active instruction changes only at update or controller reset
    always_ff @(posedge tck) begin
        if (rstTck || state == TLR) begin
            instr_q <= IR_RST;
        end else if (state == UPD_IR) begin
            instr_q <= irShift_q;
        end
    end

    // Reload request crosses to the reference clock as a toggle
    always_ff @(posedge tck) begin
        if (rstTck) begin
            cfgToggle_q <= 1'b0;
        end else if (state == UPD_IR && irShift_q == OP_CONFIG) begin
            cfgToggle_q <= ~cfgToggle_q;
        end
    end

    // Bypass cell captures zero
    always_ff @(posedge tck) begin
        if (rstTck) begin
            bypass_q <= 1'b0;
        end else if (state == CAP_DR) begin
            bypass_q <= 1'b0;
        end else if (state == SH_DR) begin
            bypass_q <= tdi;
        end
    end

    // Identity and user code share one 32-bit shifter
    always_ff @(posedge tck) begin
        if (rstTck) begin
            idShift_q <= '0;
        end else if (state == CAP_DR && drSel == DR_ID) begin
            idShift_q <= ID_WORD;
        end else if (state == CAP_DR && drSel == DR_USER) begin
            idShift_q <= user_scratch_code_q;
        end else if (state == SH_DR) begin
            idShift_q <= {tdi, idShift_q[ID_W-1:1]};
        end
    end

    // User code store; erase restores the blank value
    always_ff @(posedge tck) begin
        if (rstTck || eraseAllDone) begin
            user_scratch_code_q <= USER_SCRATCH_CODE_BLANK;
        end else if (userCodeLoad) begin
            user_scratch_code_q <= userCodeIn;
        end
    end

    // Security bit; a set in the erase cycle wins
    always_ff @(posedge tck) begin
        if (rstTck) begin
            secure_q <= SECURE_RST;
        end else if (secureSet) begin
            secure_q <= 1'b1;
        end else if (eraseAllDone) begin
            secure_q <= 1'b0;
        end
    end

    // Array access permissions under security
    assign arrayReadGrant = arrayReadReq && !secure_q;
    assign progGrant      = progReq && !secure_q;
    assign eraseGrant     = eraseReq;
    assign securityActive = secure_q;
    assign activeInstr    = instr_q;

    // Boundary cells: per output an enable cell then a value cell above it
    genvar k;
    generate
        for (k = 0; k < NOUT; k++) begin : g_outCell
            assign bsrCap[NIN + 2 * k]     = ~coreOe[k];
            assign bsrCap[NIN + 2 * k + 1] = coreOut[k];
        end
        for (k = 0; k < NIN; k++) begin : g_inCell
            assign bsrCap[k] = pinSyncB_q[k];
        end
    endgenerate

    // Boundary shifter; tdi enters the top cell
    always_ff @(posedge tck) begin
        if (rstTck) begin
            bsrShift_q <= '0;
        end else if (state == CAP_DR && drSel == DR_BSR) begin
            bsrShift_q <= bsrCap;
        end else if (state == SH_DR && drSel == DR_BSR) begin
            bsrShift_q <= {tdi, bsrShift_q[BSR_LEN-1:1]};
        end
    end

    // Update latches hold preload values until the next update
    always_ff @(posedge tck) begin
        if (rstTck) begin
            bsrUpd_q <= '0;
        end else if (state == UPD_DR && drSel == DR_BSR) begin
            bsrUpd_q <= bsrShift_q;
        end
    end

    // Pin drivers; high impedance overrides all, programming floats pins unless extest or clamp drives them
    always_ff @(posedge tck) begin
        if (rstTck) begin
            pinOut <= '0;
            pinOe  <= '0;
        end else begin
            for (int i = 0; i < NOUT; i++) begin
                if (instr_q == OP_HIGHZ) begin
                    pinOut[i] <= 1'b0;
                    pinOe[i]  <= 1'b0;
                end else if (drivesPins(instr_q)) begin
                    pinOut[i] <= bsrUpd_q[NIN + 2 * i + 1];
                    pinOe[i]  <= ~bsrUpd_q[NIN + 2 * i];
                end else if (insystemProgActive) begin
                    pinOut[i] <= 1'b0;
                    pinOe[i]  <= 1'b0;
                end else begin
                    pinOut[i] <= coreOut[i];
                    pinOe[i]  <= coreOe[i];
                end
            end
        end
    end

    // Serial output source for the current scan
    always_comb begin
        if (state == SH_IR) begin
            tdoBit = irShift_q[0];
        end else begin
            case (drSel)
                DR_ID, DR_USER: tdoBit = idShift_q[0];
                DR_BSR:         tdoBit = bsrShift_q[0];
                default:        tdoBit = bypass_q;
            endcase
        end
    end

    // Falling edge launch gives the host a full half period of setup
    always_ff @(negedge tck) begin
        if (rstTck) begin
            tdoOut <= 1'b1;
            tdoOe  <= 1'b0;
        end else begin
            tdoOut <= tdoBit;
            tdoOe  <= (state == SH_IR) || (state == SH_DR);
        end
    end

    // Open-drain trigger only ever pulls low
    cfg_pulse_gen u_pulse (
        .ref_clk     (ref_clk),
        .rst         (rst),
        .reqToggle   (cfgToggle_q),
        .pulseActive (configTriggerNOe)
    );
    assign configTriggerNOut = 1'b0;

    // Wire level observed back, for boards with several pullers
    always_ff @(posedge ref_clk) begin
        trigSyncA_q       <= configTriggerNIn;
        trigSyncB_q       <= trigSyncA_q;
        configTriggerSeen <= ~trigSyncB_q;
    end

    a_ir_capture: assert property (@(posedge tck) disable iff (rstTck)
        state == CAP_IR |=> irShift_q == {3'b000, $past(insystemProgActive), $past(secure_q), 3'b001})
        else $error("instruction capture pattern wrong");

    a_ir_update: assert property (@(posedge tck) disable iff (rstTck)
        state == UPD_IR |=> instr_q == $past(irShift_q))
        else $error("instruction not taken at update");

    a_read_blocked: assert property (@(posedge tck) disable iff (rstTck)
        secure_q |-> !arrayReadGrant && !progGrant)
        else $error("readout allowed while secured");

    a_erase_open: assert property (@(posedge tck) disable iff (rstTck)
        eraseReq |-> eraseGrant)
        else $error("erase refused");

    a_secure_hold: assert property (@(posedge tck) disable iff (rstTck)
        (secure_q && !eraseAllDone) |=> secure_q)
        else $error("security cleared without erase");

    a_bypass_zero: assert property (@(posedge tck) disable iff (rstTck)
        (state == CAP_DR && drSel == DR_BYPASS) |=> !bypass_q)
        else $error("bypass cell did not capture zero");

    a_id_capture: assert property (@(posedge tck) disable iff (rstTck)
        (state == CAP_DR && instr_q == OP_DEVICE_IDENTITY_REG) |=> idShift_q == ID_WORD && idShift_q[0])
        else $error("identity word not captured");

    a_user_blank: assert property (@(posedge tck) disable iff (rstTck)
        eraseAllDone |=> user_scratch_code_q == USER_SCRATCH_CODE_BLANK)
        else $error("user code not blank after erase");

    a_highz_float: assert property (@(posedge tck) disable iff (rstTck)
        instr_q == OP_HIGHZ ##1 instr_q == OP_HIGHZ |-> pinOe == '0)
        else $error("output driven under high impedance");

    a_isp_float: assert property (@(posedge tck) disable iff (rstTck)
        (insystemProgActive && !drivesPins(instr_q)) |=> pinOe == '0)
        else $error("output driven during programming");

endmodule // prom_tap_top
`default_nettype wire

// file: rtl/tap_state_fsm.sv
`timescale 1ns/1ps
`default_nettype none
module tap_state_fsm (
    input  wire logic                     tck,
    input  wire logic                     rstTck,
    input  wire logic                     tms,
    output var  prom_tap_pkg::tap_state_t state
);
    import prom_tap_pkg::*;

    tap_state_t stateD;

    // Sixteen-state walk steered by tms
    always_comb begin
        case (state)
            TLR:     stateD = tms ? TLR    : RTI;
            RTI:     stateD = tms ? SEL_DR : RTI;
            SEL_DR:  stateD = tms ? SEL_IR : CAP_DR;
            CAP_DR:  stateD = tms ? EX1_DR : SH_DR;
            SH_DR:   stateD = tms ? EX1_DR : SH_DR;
            EX1_DR:  stateD = tms ? UPD_DR : PA_DR;
            PA_DR:   stateD = tms ? EX2_DR : PA_DR;
            EX2_DR:  stateD = tms ? UPD_DR : SH_DR;
            UPD_DR:  stateD = tms ? SEL_DR : RTI;
            SEL_IR:  stateD = tms ? TLR    : CAP_IR;
            CAP_IR:  stateD = tms ? EX1_IR : SH_IR;
            SH_IR:   stateD = tms ? EX1_IR : SH_IR;
            EX1_IR:  stateD = tms ? UPD_IR : PA_IR;
            PA_IR:   stateD = tms ? EX2_IR : PA_IR;
            EX2_IR:  stateD = tms ? UPD_IR : SH_IR;
            UPD_IR:  stateD = tms ? SEL_DR : RTI;
            default: stateD = TLR;
        endcase
    end

    // Mode select taken on each rising test clock
    always_ff @(posedge tck) begin
        if (rstTck) begin
            state <= TLR;
        end else begin
            state <= stateD;
        end
    end

    a_tms_reset: assert property (@(posedge tck) disable iff (rstTck)
        tms [*5] |=> state == TLR)
        else $error("five high tms did not reach reset state");

    a_tms_step: assert property (@(posedge tck) disable iff (rstTck)
        (state == RTI && !tms) |=> state == RTI)
        else $error("idle state left with tms low");

endmodule // tap_state_fsm
`default_nettype wire

// file: verif/jtag_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// Test-port host; its test clock only runs inside these tasks
module jtag_host_model (
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    input  wire logic tdoOut
);
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
    end

    // One period; tms/tdi settle with tck low, tdo read before the rising edge
    task automatic step(input logic m, input logic d, output logic q);
        tms = m;
        tdi = d;
        #15;
        q = tdoOut;
        tck = 1'b1;
        #15;
        tck = 1'b0;
    endtask

    // Idle clocks, tms held at one level
    task automatic idle(input int n, input logic m);
        logic q;
        for (int i = 0; i < n; i++) begin
            step(m, 1'b1, q);
        end
    endtask

    // Full scan from idle back to idle, low bit first
    task automatic scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
        logic q;
        dout = '0;
        step(1'b1, 1'b1, q);
        if (ir) begin
            step(1'b1, 1'b1, q);
        end
        step(1'b0, 1'b1, q);
        step(1'b0, 1'b1, q);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], q);
            dout[i] = q;
        end
        step(1'b1, 1'b1, q);
        step(1'b0, 1'b1, q); // Instruction lands here
    endtask
endmodule // jtag_host_model
`default_nettype wire

// file: verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import prom_tap_pkg::*;
    localparam int NOUT = 8;
    localparam int NIN  = 4;
    localparam int BW   = NIN + 2 * NOUT;
    logic            ref_clk, rst, tck, tms, tdi, tdoOut, tdoOe, cfgOut, cfgOe, cfgSeen;
    logic            isp, secSet, eraseDone, ucLoad, rdReq, prReq, erReq, rdGnt, prGnt, erGnt;
    logic            secAct, expSec;
    logic [7:0]      actInstr;
    logic [7:0]      ops [8];
    logic [31:0]     ucIn, dout, din;
    logic [NOUT-1:0] coreOut, coreOe, pinOut, pinOe;
    logic [NIN-1:0]  pinIn;
    int              n_mismatch, check_count;
    int              pulseLen = 0;
    int              seed = 32'h24f417a7;
    wire             cfgWireN = cfgOe ? cfgOut : 1'b1; // Open drain, pulled up

    prom_tap_top #(.NOUT(NOUT), .NIN(NIN)) prom_tap_top_i (.ref_clk(ref_clk), .rst(rst), .tck(tck),
        .tms(tms), .tdi(tdi), .tdoOut(tdoOut), .tdoOe(tdoOe), .configTriggerNIn(cfgWireN),
        .configTriggerNOut(cfgOut), .configTriggerNOe(cfgOe), .configTriggerSeen(cfgSeen),
        .insystemProgActive(isp), .secureSet(secSet), .eraseAllDone(eraseDone),
        .userCodeLoad(ucLoad), .userCodeIn(ucIn), .arrayReadReq(rdReq), .progReq(prReq),
        .eraseReq(erReq), .arrayReadGrant(rdGnt), .progGrant(prGnt), .eraseGrant(erGnt),
        .securityActive(secAct), .activeInstr(actInstr), .coreOut(coreOut), .coreOe(coreOe),
        .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe));
    jtag_host_model jtag_host_model_i (.tck(tck), .tms(tms), .tdi(tdi), .tdoOut(tdoOut));

    initial begin
        ref_clk = 1'b0;
        #1.3; // Keeps reference edges off the test clock edges
        forever #2.5 ref_clk = ~ref_clk;
    end

    // Reload pulse width in reference cycles
    always @(posedge ref_clk) begin
        if (cfgOe) begin
            pulseLen <= pulseLen + 1;
        end
    end

    function automatic logic [7:0] irCap(input logic ispV, input logic secV);
        return {3'b000, ispV, secV, 1'b0, 2'b01};
    endfunction

    function automatic logic [31:0] idWord();
        return {ID_VER_DEF, ID_FAM_DEF, ID_PROD_DEF, ID_COMP_DEF, 1'b1};
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic close_out();
        $display("checks=%0d mismatches=%0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic tick(input int n);
        jtag_host_model_i.idle(n, 1'b0);
    endtask

    task automatic ld(input logic [7:0] op);
        jtag_host_model_i.scan(1'b1, 8, {24'h0, op}, dout);
    endtask

    task automatic rdDr(input int n);
        jtag_host_model_i.scan(1'b0, n, din, dout);
    endtask

    // Every request mix against the expected security state
    task automatic grants();
        for (int k = 0; k < 8; k++) begin
            {rdReq, prReq, erReq} = 3'(k);
            #1;
            check(secAct, expSec);
            check({rdGnt, prGnt, erGnt}, {rdReq & ~expSec, prReq & ~expSec, erReq});
        end
    endtask

    initial begin
        ops = '{OP_BYPASS, OP_SAMPLE, OP_EXTEST, OP_CLAMP, OP_HIGHZ, OP_DEVICE_IDENTITY_REG, OP_USER_SCRATCH_CODE, 8'h5b};
        {rst, isp, secSet, eraseDone, ucLoad, rdReq, prReq, erReq, expSec} = 9'h100;
        {ucIn, din, coreOut, coreOe, pinIn} = '0;
        n_mismatch = 0;
        check_count = 0;
        // Reset held while tck runs so both domains see it
        jtag_host_model_i.idle(6, 1'b1);
        @(negedge ref_clk);
        rst = 1'b0;
        jtag_host_model_i.idle(4, 1'b1);
        tick(1);
        check(actInstr, OP_DEVICE_IDENTITY_REG);
        check(tdoOe, 1'b0);
        // Park in shift-DR: serial output must be enabled there
        jtag_host_model_i.step(1'b1, 1'b1, dout[0]);
        jtag_host_model_i.step(1'b0, 1'b1, dout[0]);
        jtag_host_model_i.step(1'b0, 1'b1, dout[0]);
        #1;
        check(tdoOe, 1'b1);
        jtag_host_model_i.step(1'b1, 1'b1, dout[0]);
        jtag_host_model_i.step(1'b1, 1'b1, dout[0]);
        jtag_host_model_i.step(1'b0, 1'b1, dout[0]);
        din = $random(seed);
        rdDr(32);
        check(dout, idWord());
        $display("test identity done");
        // Blank user code, then a loaded one
        ld(OP_USER_SCRATCH_CODE);
        rdDr(32);
        check(dout, 32'hffffffff);
        ucIn = $random(seed);
        ucLoad = 1'b1;
        tick(1);
        ucLoad = 1'b0;
        rdDr(32);
        check(dout, ucIn);
        $display("test user code done");
        // Capture pattern over all status mixes; security set halfway
        for (int k = 0; k < 4; k++) begin
            isp = k[0];
            if (k == 2) begin
                secSet = 1'b1;
                tick(1);
                secSet = 1'b0;
                expSec = 1'b1;
            end
            ld(OP_BYPASS);
            check(dout[7:0], irCap(k[0], k[1]));
            grants();
        end
        eraseDone = 1'b1;
        tick(1);
        eraseDone = 1'b0;
        expSec = 1'b0;
        isp = 1'b0;
        grants();
        ld(OP_USER_SCRATCH_CODE);
        rdDr(32);
        check(dout, 32'hffffffff);
        $display("test security done");
        // Each opcode except reload, plus an unknown one
        for (int k = 0; k < 8; k++) begin
            ld(ops[k]);
            check(actInstr, ops[k]);
            din = $random(seed);
            rdDr(8);
            if (ops[k] inside {OP_BYPASS, OP_CLAMP, 8'h5b}) begin
                check(dout[7:0], {din[6:0], 1'b0});
            end
            if (ops[k] == OP_HIGHZ) begin
                check(pinOe, '0);
            end
        end
        // Five high mode-select clocks return the controller to reset
        jtag_host_model_i.idle(5, 1'b1);
        tick(1);
        check(actInstr, OP_DEVICE_IDENTITY_REG);
        $display("test opcodes done");
        // Sample pins, preload cells, then drive them out
        pinIn = NIN'($random(seed));
        coreOut = NOUT'($random(seed));
        coreOe = NOUT'($random(seed));
        ld(OP_SAMPLE);
        din = $random(seed);
        rdDr(BW);
        check(dout[NIN-1:0], pinIn);
        for (int k = 0; k < NOUT; k++) begin
            check({dout[NIN+2*k+1], dout[NIN+2*k]}, {coreOut[k], ~coreOe[k]});
        end
        ld(OP_EXTEST);
        tick(2);
        for (int k = 0; k < NOUT; k++) begin
            check({pinOe[k], pinOut[k]}, {~din[NIN+2*k], din[NIN+2*k+1]});
        end
        ld(OP_BYPASS);
        tick(2);
        check({pinOe, pinOut}, {coreOe, coreOut});
        isp = 1'b1;
        tick(2);
        check(pinOe, '0);
        isp = 1'b0;
        $display("test pins done");
        // Reload pulse must last 300 to 500 ns
        ld(OP_CONFIG);
        repeat (30) @(negedge ref_clk);
        check(cfgSeen, 1'b1);
        repeat (90) @(negedge ref_clk);
        check(cfgSeen, 1'b0);
        check(pulseLen * 5 >= 300 && pulseLen * 5 <= 500, 1'b1);
        check(cfgOut, 1'b0);
        $display("test reload done");
        close_out();
    end

    // Hang guard
    initial begin
        #300000;
        n_mismatch++;
        close_out();
    end
endmodule // testbench
`default_nettype wire
